// *** verilog/sece_engine.sv ***
`timescale 1ns/1ps
`default_nettype none

// Three-stage pin synchroniser: the output only follows once stages two and three agree
module sece_sync3
#(
   parameter logic INIT = 1'b0
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic d,
   output logic q
);
   logic s1_reg; // First stage, read only by the second
   logic s2_reg; // Second stage
   logic s3_reg; // Third stage

   // Shift chain
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1_reg <= INIT;
         s2_reg <= INIT;
         s3_reg <= INIT;
      end
      else
      begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Filtered level; a one-stage disagreement is treated as noise
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         q <= INIT;
      else if (s2_reg == s3_reg)
         q <= s3_reg;
   end
endmodule

module sece_engine
#(
   parameter int WRITE_CYCLES = sece_pkg::WRITE_CYCLES_DEF // Shorten in simulation
)
(
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic CS_N,
   input wire logic SERIAL_CLOCK_IN,
   input wire logic SERIAL_DATA_IN,
   input wire logic PROTECT_N,
   output logic SERIAL_DATA_OUT,
   output logic SERIAL_DATA_OUT_OE,
   output logic WRITE_BUSY
);
   import sece_pkg::*;

   // Array lives in the reference domain; the link only reads it
   logic [DATA_W-1:0] mem [0:WORDS-1];

   // Link domain: frame state, cleared whenever the frame is not live
   sece_state_e state_reg; // Frame state
   logic [CNT_W-1:0] cnt_reg; // Bits taken in the current field
   logic [OPC_W-1:0] opc_reg; // Received opcode
   logic [BIT_W-1:0] bit_reg; // Index of the bit being shifted out
   logic [DATA_W-1:0] word_reg; // Word being shifted out
   logic start_seen_reg; // Start bit recognised in this frame
   logic do_bit_reg; // Read data bit on the output
   logic rd_oe_reg; // Read data is being driven

   // Link domain: kept across frames, untouched by the frame reset, reset only by RESET
   logic [ADDR_W-1:0] addr_reg; // Command address and read pointer
   logic [DATA_W-1:0] data_reg; // Last sixteen data bits
   logic wen_reg; // Write enable mode
   logic armed_reg; // Complete enabled program command held
   logic prog_tog_reg; // Flips once per armed program command
   logic start_tog_reg; // Flips on each recognised start bit

   // Reference domain
   logic cs_n_s; // Synchronised chip select
   logic cs_n_d_reg; // Previous synchronised chip select
   logic prot_n_s; // Synchronised protect pin
   logic armed_s; // Synchronised armed flag
   logic prog_tog_s; // Synchronised program toggle
   logic start_tog_s; // Synchronised start toggle
   logic start_tog_d_reg; // Previous synchronised start toggle
   logic done_tog_reg; // Program toggle already serviced
   logic busy_reg; // Self-timed write in progress
   logic verify_reg; // A write has run, verify output pending
   logic [TMR_W-1:0] tmr_reg; // Write period counter

   logic link_rst; // Frame reset
   logic link_live; // Frame may act on its inputs
   logic [ADDR_W-1:0] addr_next; // Address with the new bit shifted in
   logic [ADDR_W-1:0] addr_inc; // Next sequential read address
   logic cs_rise; // Chip select released
   logic write_start; // Start the self-timed write
   logic start_evt; // Start bit seen in the link domain

   // Chip select high, reset or a busy write all hold the frame idle.
   // Busy only falls while the host keeps data input low, so the release
   // cannot land on a start bit.
   assign link_rst = RESET | CS_N | busy_reg;
   assign link_live = ~CS_N & ~busy_reg;
   assign addr_next = {addr_reg[ADDR_W-2:0], SERIAL_DATA_IN};
   assign addr_inc = addr_reg + ADDR_ONE; // Natural wrap from all ones

   // Frame state machine, sampling on rising serial clock
   always_ff @(posedge SERIAL_CLOCK_IN or posedge link_rst)
   begin
      if (link_rst)
      begin
         state_reg <= SECE_WAIT_START;
         cnt_reg <= CNT_ZERO;
         opc_reg <= OPC_READ;
         bit_reg <= BIT_FIRST;
         word_reg <= DATA_ZERO;
         start_seen_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            SECE_WAIT_START:
            begin
               // Low data clocks before the start bit are skipped
               if (SERIAL_DATA_IN)
               begin
                  start_seen_reg <= 1'b1;
                  state_reg <= SECE_OPCODE;
                  cnt_reg <= CNT_ZERO;
               end
            end
            SECE_OPCODE:
            begin
               opc_reg <= {opc_reg[OPC_W-2:0], SERIAL_DATA_IN};
               if (cnt_reg == OPC_LAST)
               begin
                  state_reg <= SECE_ADDRESS;
                  cnt_reg <= CNT_ZERO;
               end
               else
                  cnt_reg <= cnt_reg + CNT_ONE;
            end
            SECE_ADDRESS:
            begin
               if (cnt_reg == ADDR_LAST)
               begin
                  cnt_reg <= CNT_ZERO;
                  case (opc_reg)
                     OPC_READ:
                     begin
                        // Array is quiet whenever a frame is live, so the
                        // cross-domain read sees stable data
                        word_reg <= mem[addr_next];
                        bit_reg <= BIT_FIRST;
                        state_reg <= SECE_READ_OUT;
                     end
                     OPC_PROGRAM:
                        state_reg <= SECE_DATA;
                     default:
                        state_reg <= SECE_DONE; // Mode commands end here
                  endcase
               end
               else
                  cnt_reg <= cnt_reg + CNT_ONE;
            end
            SECE_DATA:
            begin
               // Counter saturates; overflow bits keep shifting
               if (cnt_reg != DATA_FULL)
                  cnt_reg <= cnt_reg + CNT_ONE;
            end
            SECE_READ_OUT:
            begin
               if (bit_reg == BIT_LAST)
               begin
                  word_reg <= mem[addr_inc];
                  bit_reg <= BIT_FIRST;
               end
               else
                  bit_reg <= bit_reg - BIT_ONE;
            end
            SECE_DONE:
               state_reg <= SECE_DONE; // Ignore clocks until deselect
            default:
               state_reg <= SECE_WAIT_START;
         endcase
      end
   end

   // Output shift on falling serial clock
   always_ff @(negedge SERIAL_CLOCK_IN or posedge link_rst)
   begin
      if (link_rst)
      begin
         do_bit_reg <= 1'b0;
         rd_oe_reg <= 1'b0;
      end
      else if (state_reg == SECE_READ_OUT)
      begin
         do_bit_reg <= word_reg[bit_reg];
         rd_oe_reg <= 1'b1;
      end
   end

   // Command results that must outlive the frame
   always_ff @(posedge SERIAL_CLOCK_IN or posedge RESET)
   begin
      if (RESET)
      begin
         addr_reg <= ADDR_ZERO;
         data_reg <= DATA_ZERO;
         wen_reg <= 1'b0; // Powers up write-disabled
         armed_reg <= 1'b0;
         prog_tog_reg <= 1'b0;
         start_tog_reg <= 1'b0;
      end
      else if (link_live)
      begin
         case (state_reg)
            SECE_WAIT_START:
            begin
               if (SERIAL_DATA_IN)
               begin
                  armed_reg <= 1'b0; // A new command drops the old one
                  start_tog_reg <= ~start_tog_reg;
               end
            end
            SECE_ADDRESS:
            begin
               addr_reg <= addr_next;
               if (cnt_reg == ADDR_LAST)
               begin
                  if (opc_reg == OPC_WRITE_ENABLE)
                     wen_reg <= 1'b1;
                  else if (opc_reg == OPC_WRITE_DISABLE)
                     wen_reg <= 1'b0;
               end
            end
            SECE_DATA:
            begin
               data_reg <= {data_reg[DATA_W-2:0], SERIAL_DATA_IN};
               // Armed only when the full word is in and writes are enabled
               if (cnt_reg == DATA_LAST && wen_reg)
               begin
                  armed_reg <= 1'b1;
                  prog_tog_reg <= ~prog_tog_reg;
               end
            end
            SECE_READ_OUT:
            begin
               if (bit_reg == BIT_LAST)
                  addr_reg <= addr_inc;
            end
            default:
               addr_reg <= addr_reg;
         endcase
      end
   end

   // Pin and link levels into the reference domain
   sece_sync3 #(.INIT(1'b1)) u_cs_sync
   (
      .clk(REF_CLK),
      .rst(RESET),
      .d(CS_N),
      .q(cs_n_s)
   );
   // Pull-down default: protected until the pin is seen high
   sece_sync3 #(.INIT(1'b0)) u_prot_sync
   (
      .clk(REF_CLK),
      .rst(RESET),
      .d(PROTECT_N),
      .q(prot_n_s)
   );
   sece_sync3 #(.INIT(1'b0)) u_armed_sync
   (
      .clk(REF_CLK),
      .rst(RESET),
      .d(armed_reg),
      .q(armed_s)
   );
   sece_sync3 #(.INIT(1'b0)) u_prog_sync
   (
      .clk(REF_CLK),
      .rst(RESET),
      .d(prog_tog_reg),
      .q(prog_tog_s)
   );
   sece_sync3 #(.INIT(1'b0)) u_start_sync
   (
      .clk(REF_CLK),
      .rst(RESET),
      .d(start_tog_reg),
      .q(start_tog_s)
   );

   // Command words are static once the serial clock stops, so they are
   // taken directly once the armed flag has crossed
   assign cs_rise = cs_n_s & ~cs_n_d_reg;
   assign write_start = cs_rise & armed_s & (prog_tog_s != done_tog_reg) & ~busy_reg;
   assign start_evt = start_tog_s ^ start_tog_d_reg;

   // Edge history in the reference domain
   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         cs_n_d_reg <= 1'b1;
         start_tog_d_reg <= 1'b0;
         done_tog_reg <= 1'b0;
      end
      else
      begin
         cs_n_d_reg <= cs_n_s;
         start_tog_d_reg <= start_tog_s;
         if (write_start)
            done_tog_reg <= prog_tog_s; // Each command writes once
      end
   end

   // Self-timed write period
   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         busy_reg <= 1'b0;
         tmr_reg <= TMR_ZERO;
      end
      else if (write_start)
      begin
         busy_reg <= 1'b1; // Runs even when the word is protected
         tmr_reg <= TMR_ZERO;
      end
      else if (busy_reg)
      begin
         if (tmr_reg == TMR_W'(WRITE_CYCLES - 1))
            busy_reg <= 1'b0;
         else
            tmr_reg <= tmr_reg + TMR_ONE;
      end
   end

   // Array update, no erase step needed
   always_ff @(posedge REF_CLK)
   begin
      // Lower half stays untouched while protect is low
      if (write_start && (prot_n_s || addr_reg[PROT_BIT]))
         mem[addr_reg] <= data_reg;
   end

   // Verify window: set by a write, cleared by the next start bit
   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
         verify_reg <= 1'b0;
      else if (write_start)
         verify_reg <= 1'b1; // Set wins over a coincident clear
      else if (start_evt)
         verify_reg <= 1'b0;
   end

   // Output pin: busy/ready level during verify, read data otherwise.
   // The start bit releases the pin at once, before the clear crosses.
   assign SERIAL_DATA_OUT = (verify_reg && !rd_oe_reg) ? ~busy_reg : do_bit_reg;
   assign SERIAL_DATA_OUT_OE = ~CS_N & (rd_oe_reg | (verify_reg & ~start_seen_reg));
   assign WRITE_BUSY = busy_reg;
endmodule

`default_nettype wire

// *** common/sece_pkg.sv ***
// Shared constants of the serial EEPROM command engine
package sece_pkg;

   // Array shape: 256 words of 16 bits, address field of 8 bits
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int WORDS = 256;

   // Opcode field follows the start bit; codes are free to change here
   localparam int OPC_W = 2;
   localparam logic [1:0] OPC_READ = 2'h2;
   localparam logic [1:0] OPC_PROGRAM = 2'h1;
   localparam logic [1:0] OPC_WRITE_ENABLE = 2'h0;
   localparam logic [1:0] OPC_WRITE_DISABLE = 2'h3;

   // Bit counters of the serial frame
   localparam int CNT_W = 5;
   localparam int BIT_W = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
   localparam logic [CNT_W-1:0] OPC_LAST = 5'h01;
   localparam logic [CNT_W-1:0] ADDR_LAST = 5'h07;
   localparam logic [CNT_W-1:0] DATA_LAST = 5'h0f;
   localparam logic [CNT_W-1:0] DATA_FULL = 5'h10;
   localparam logic [BIT_W-1:0] BIT_FIRST = 4'hf;
   localparam logic [BIT_W-1:0] BIT_LAST = 4'h0;
   localparam logic [BIT_W-1:0] BIT_ONE = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_ONE = 8'h01;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

   // Protected bank is the lower half: top address bit clear
   localparam int PROT_BIT = ADDR_W - 1;

   // Self-timed write period on the 100 MHz reference clock
   localparam int CLK_PERIOD_NS = 10;
   localparam int WRITE_TIME_US = 4000;
   localparam int WRITE_MAX_US = 10000;
   localparam int WRITE_CYCLES_DEF = WRITE_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int WRITE_MAX_CYCLES = WRITE_MAX_US * 1000 / CLK_PERIOD_NS;
   localparam int TMR_W = 20;
   localparam logic [TMR_W-1:0] TMR_ZERO = 20'h00000;
   localparam logic [TMR_W-1:0] TMR_ONE = 20'h00001;

   // Serial frame states
   typedef enum logic [2:0] {
      SECE_WAIT_START,
      SECE_OPCODE,
      SECE_ADDRESS,
      SECE_DATA,
      SECE_READ_OUT,
      SECE_DONE
   } sece_state_e;

endpackage

// *** tb/sece_engine_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the command engine, all on the reference clock
module sece_engine_props
#(
   parameter int WRITE_CYCLES = 400 // Must match the engine instance
)
(
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic CS_N,
   input wire logic SERIAL_CLOCK_IN,
   input wire logic SERIAL_DATA_IN,
   input wire logic PROTECT_N,
   input wire logic SERIAL_DATA_OUT,
   input wire logic SERIAL_DATA_OUT_OE,
   input wire logic WRITE_BUSY
);
   logic [31:0] busy_cnt; // Cycles busy has been seen high so far

   // Counting keeps long write periods out of repetition operators
   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
         busy_cnt <= '0;
      else if (WRITE_BUSY)
         busy_cnt <= busy_cnt + 32'h1;
      else
         busy_cnt <= '0;
   end

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RESET);

   a_idle_released: assert property (CS_N |-> !SERIAL_DATA_OUT_OE)
      else $error("output driven while deselected");
   a_busy_exact: assert property ($fell(WRITE_BUSY) |-> busy_cnt == WRITE_CYCLES)
      else $error("write period length wrong");
   a_busy_bound: assert property (busy_cnt <= WRITE_CYCLES)
      else $error("write period overran");
   a_write_on_release: assert property ($rose(WRITE_BUSY) |-> CS_N && $past(CS_N, 3))
      else $error("write started without deselect");
   a_busy_holds: assert property ($rose(WRITE_BUSY) |=> WRITE_BUSY[*8])
      else $error("write period cut short");
   a_verify_low: assert property (!CS_N && SERIAL_DATA_OUT_OE && WRITE_BUSY |-> !SERIAL_DATA_OUT)
      else $error("verify shows ready while busy");
   a_verify_driven: assert property (WRITE_BUSY && !CS_N |-> SERIAL_DATA_OUT_OE)
      else $error("verify output not driven");
   a_ready_high: assert property ($fell(WRITE_BUSY) && !CS_N && SERIAL_DATA_OUT_OE |-> ##[0:2] SERIAL_DATA_OUT)
      else $error("ready level missing after write");
   a_no_rewrite: assert property ($fell(WRITE_BUSY) |=> !WRITE_BUSY[*6])
      else $error("write restarted without a frame");
endmodule
`default_nettype wire

// *** tb/sece_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// Host side of the link; its clock idles low between frames
module sece_host
(
   output logic cs_n,
   output logic sclk,
   output logic di,
   input wire logic dout,
   input wire logic oe
);
   wire logic pin; // Released pin reads inverted so a stale bit never passes
   assign pin = oe ? dout : ~dout;

   // Deselected and quiet at start
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b0;
      di = 1'b0;
   end

   // Select with data low so no false start bit is seen
   task automatic sel();
      di = 1'b0;
      cs_n = 1'b0;
      #203.3;
   endtask

   // Data set while the clock is low, taken on the rising edge
   task automatic shift(input int n, input logic [31:0] v);
      for (int i = n - 1; i >= 0; i--)
      begin
         di = v[i];
         #80 sclk = 1'b1;
         #80 sclk = 1'b0;
      end
   endtask

   // Bits sampled mid low phase, well away from the falling edge
   task automatic get(output logic [15:0] w);
      w = 16'h0000;
      di = 1'b0;
      for (int i = 0; i < 16; i++)
      begin
         #40 w = {w[14:0], pin};
         #40 sclk = 1'b1;
         #80 sclk = 1'b0;
      end
   endtask

   // Release with the clock low; deselect time kept before the next frame
   task automatic desel();
      #80 cs_n = 1'b1;
      #300;
   endtask
endmodule
`default_nettype wire

// *** tb/sece_engine_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module sece_engine_tb_top;
   import sece_pkg::*;
   localparam int WC = 400; // Short write period, longer than a mode frame
   logic ref_clk = 1'b0;
   logic reset = 1'b0; // Raised just after time zero so every reset process sees a clean edge
   logic protect_n = 1'b1; // Lower half open unless a test lowers it
   wire logic cs_n;
   wire logic sclk;
   wire logic di;
   logic dout;
   logic oe;
   logic busy;
   int err_count = 0;
   int num_checks = 0;

   // Reference clock, 10 ns
   always #5 ref_clk = ~ref_clk;

   sece_engine #(.WRITE_CYCLES(WC)) uut (.REF_CLK(ref_clk), .RESET(reset), .CS_N(cs_n),
      .SERIAL_CLOCK_IN(sclk), .SERIAL_DATA_IN(di), .PROTECT_N(protect_n),
      .SERIAL_DATA_OUT(dout), .SERIAL_DATA_OUT_OE(oe), .WRITE_BUSY(busy));
   sece_host host (.cs_n(cs_n), .sclk(sclk), .di(di), .dout(dout), .oe(oe));

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask

   task automatic chkb(input string nm, input logic e, input logic g);
      num_checks++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
         err_count++;
      end
   endtask

   // Bounded wait on the busy flag; running out ends the run
   task automatic wait_busy(input logic lvl, input int lim);
      int k;
      k = 0;
      while (busy !== lvl && k < lim)
      begin
         @(posedge ref_clk);
         #2;
         k++;
      end
      if (busy !== lvl)
      begin
         $display("[FAIL] busy wait expected %b seen %b", lvl, busy);
         err_count++;
         close_out();
      end
   endtask

   task automatic wait_write();
      wait_busy(1'b1, 40);
      wait_busy(1'b0, WC + 40);
   endtask

   // Start bit, opcode and address, chip select left low
   task automatic cmd(input logic [1:0] opc, input logic [7:0] a);
      host.sel();
      host.shift(11, {21'h0, 1'b1, opc, a});
   endtask

   task automatic prog(input logic [7:0] a, input int n, input logic [31:0] v);
      cmd(OPC_PROGRAM, a);
      host.shift(n, v);
      host.desel();
   endtask

   task automatic mode(input logic [1:0] opc);
      cmd(opc, 8'h00);
      host.desel();
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] w0, output logic [15:0] w1);
      cmd(OPC_READ, a);
      host.get(w0);
      host.get(w1);
      host.desel();
   endtask

   // Disabled after reset, then enable, program, verify and read back
   task automatic t_first();
      logic [15:0] w0;
      host.sel();
      chkb("verify before write", 1'b0, oe);
      host.desel();
      prog(8'h85, 16, 32'h1111);
      repeat (40) @(posedge ref_clk);
      #2;
      chkb("busy without enable", 1'b0, busy);
      mode(OPC_WRITE_ENABLE);
      prog(8'h85, 16, 32'ha5c3);
      wait_busy(1'b1, 40);
      host.sel();
      chkb("verify enable", 1'b1, oe);
      chkb("verify busy", 1'b0, host.pin);
      wait_busy(1'b0, WC + 40);
      repeat (4) @(posedge ref_clk);
      chkb("verify ready", 1'b1, host.pin);
      host.shift(1, 32'h1);
      chkb("start releases", 1'b0, oe);
      host.shift(10, {22'h0, OPC_READ, 8'h85});
      host.get(w0);
      host.desel();
      chk("word 85", 16'ha5c3, w0);
      $display("t_first done");
   endtask

   // Overlong data, rollover of the read address, leading idle clocks
   task automatic t_wrap();
      logic [15:0] w0;
      logic [15:0] w1;
      prog(8'hff, 20, 32'hf1234);
      wait_write();
      prog(8'h00, 16, 32'h5678);
      wait_write();
      host.sel();
      host.shift(13, {19'h0, 2'b00, 1'b1, OPC_READ, 8'hff});
      host.get(w0);
      host.get(w1);
      host.desel();
      chk("word ff", 16'h1234, w0);
      chk("word 00", 16'h5678, w1);
      $display("t_wrap done");
   endtask

   // Protected bank keeps its word but the write period still runs
   task automatic t_protect();
      logic [15:0] w0;
      logic [15:0] w1;
      @(posedge ref_clk);
      #2 protect_n = 1'b0;
      prog(8'h00, 16, 32'hffff);
      wait_write();
      @(posedge ref_clk);
      #2 protect_n = 1'b1;
      rd(8'h00, w0, w1);
      chk("protected word", 16'h5678, w0);
      $display("t_protect done");
   endtask

   // A frame sent while busy is dropped: enable survives a disable frame
   task automatic t_ignore();
      prog(8'h86, 16, 32'h0f0f);
      wait_busy(1'b1, 40);
      mode(OPC_WRITE_DISABLE);
      chkb("busy after frame", 1'b1, busy);
      wait_busy(1'b0, WC + 40);
      prog(8'h87, 16, 32'h7777);
      wait_write();
      $display("t_ignore done");
   endtask

   // Disable mode refuses a program and leaves the array alone
   task automatic t_disable();
      logic [15:0] w0;
      logic [15:0] w1;
      mode(OPC_WRITE_DISABLE);
      prog(8'h86, 16, 32'hdead);
      repeat (40) @(posedge ref_clk);
      #2;
      chkb("busy when disabled", 1'b0, busy);
      rd(8'h86, w0, w1);
      chk("word 86", 16'h0f0f, w0);
      chk("word 87", 16'h7777, w1);
      $display("t_disable done");
   endtask

   // Main sequence
   initial
   begin
      #1 reset = 1'b1;
      repeat (4) @(posedge ref_clk);
      #2 reset = 1'b0;
      repeat (4) @(posedge ref_clk);
      // An empty select gives the frame reset a clean edge before the first command
      host.sel();
      host.desel();
      t_first();
      t_wrap();
      t_protect();
      t_ignore();
      t_disable();
      close_out();
   end
endmodule

bind sece_engine sece_engine_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (.REF_CLK(REF_CLK), .RESET(RESET),
   .CS_N(CS_N), .SERIAL_CLOCK_IN(SERIAL_CLOCK_IN), .SERIAL_DATA_IN(SERIAL_DATA_IN), .PROTECT_N(PROTECT_N),
   .SERIAL_DATA_OUT(SERIAL_DATA_OUT), .SERIAL_DATA_OUT_OE(SERIAL_DATA_OUT_OE), .WRITE_BUSY(WRITE_BUSY));
`default_nettype wire
